// [hdl/mifm_top.sv]
/*
 * mifm_top: maskable interrupt flag mapper, pending, mask, level and
 * default-order arbitration for 19 sources, plus the illegal-opcode reset.
 * assumes: cpu core supplies global enable and in-service level and pulses
 * an acknowledge; source events are one-cycle pulses on this clock.
 */
`timescale 1ns/1ps
module mifm_top #(
   parameter bit LARGE_PKG = 1'b1
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_watchdog_interval_irq,
   input wire logic [3:0] i_external_pin_irq,
   input wire logic i_uart_tx_end_irq,
   input wire logic i_sync_serial_a_end_irq,
   input wire logic i_simple_twowire_end_irq,
   input wire logic i_uart_rx_end_irq,
   input wire logic i_sync_serial_b_end_irq,
   input wire logic i_uart_rx_error_irq,
   input wire logic i_timer_ch1_upper_irq,
   input wire logic i_timer_ch0_irq,
   input wire logic i_timer_ch1_irq,
   input wire logic i_conversion_done_irq,
   input wire logic i_key_return_irq,
   input wire logic i_timer_ch3_upper_irq,
   input wire logic i_full_twowire_end_irq,
   input wire logic i_timer_ch2_irq,
   input wire logic i_timer_ch3_irq,
   input wire logic i_interval_timer_irq,
   input wire logic i_comparator_edge_irq,
   input wire logic i_global_accept_enable,
   input wire logic i_in_service_level_bit0,
   input wire logic i_in_service_level_bit1,
   input wire logic i_ack,
   input wire logic i_exec_valid,
   input wire logic [7:0] i_exec_opcode,
   input wire logic i_debug_active,
   output logic o_req,
   output logic [4:0] o_req_id,
   output logic o_trap_reset,
   output logic o_irq
);
   localparam int N = mifm_pkg::NUM_SRC;
   localparam logic [23:0] IMPL = LARGE_PKG ? 24'h07FFFF : 24'h0007FF;

   logic [23:0] pend_q;
   logic [23:0] mask_q;
   logic [23:0] lv0_q;
   logic [23:0] lv1_q;
   logic [7:0] rise_q;
   logic [7:0] fall_q;
   logic [2:0] stat_q;
   logic [2:0] smask_q;
   logic [3:0] pin_edge;
   logic [23:0] src_ev;
   logic [23:0] ack_clr;
   logic [23:0] sw_wr;
   logic [23:0] sw_data;
   logic trap_ev;
   logic cand_ok;
   logic [4:0] win_id;
   logic [1:0] win_lv;

   mifm_edge_detect #(.N(4)) u_edge (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_pin(i_external_pin_irq),
      .i_rise_en(rise_q[3:0]),
      .i_fall_en(fall_q[3:0]),
      .o_edge(pin_edge)
   );

   mifm_trap_reset u_trap (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_exec_valid(i_exec_valid),
      .i_exec_opcode(i_exec_opcode),
      .i_debug_active(i_debug_active),
      .o_trap_reset(o_trap_reset),
      .o_trap_event(trap_ev)
   );

   // pins 2 and 3 of the small package are dropped here by the implemented-bit mask,
   // after the synchroniser, so no logic sits in front of the first flop
   // large package placement, masked down to bits 0 to 10 for the small package
   always_comb begin
      src_ev = '0;
      src_ev[0] = i_watchdog_interval_irq;
      src_ev[1] = pin_edge[0];
      src_ev[2] = pin_edge[1];
      src_ev[mifm_pkg::BIT_TX_SHARED] = i_uart_tx_end_irq | i_sync_serial_a_end_irq |
                                        i_simple_twowire_end_irq;
      src_ev[mifm_pkg::BIT_RX_SHARED] = i_uart_rx_end_irq |
                                        (LARGE_PKG & i_sync_serial_b_end_irq);
      src_ev[5] = i_uart_rx_error_irq;
      src_ev[6] = i_timer_ch1_upper_irq;
      src_ev[7] = i_timer_ch0_irq;
      src_ev[8] = i_timer_ch1_irq;
      src_ev[9] = i_conversion_done_irq;
      src_ev[10] = i_key_return_irq;
      src_ev[11] = pin_edge[2];
      src_ev[12] = pin_edge[3];
      src_ev[13] = i_timer_ch3_upper_irq;
      src_ev[14] = i_full_twowire_end_irq;
      src_ev[15] = i_timer_ch2_irq;
      src_ev[16] = i_timer_ch3_irq;
      src_ev[17] = i_interval_timer_irq;
      src_ev[18] = i_comparator_edge_irq;
      src_ev = src_ev & IMPL;
   end

   // byte lane write decode for the three register groups
   function automatic logic [23:0] lane_wr(input logic [3:0] a, input logic [3:0] base);
      lane_wr = '0;
      if (a == base) lane_wr[7:0] = 8'hFF;
      if (a == base + 4'h1) lane_wr[15:8] = 8'hFF;
      if (a == base + 4'h2) lane_wr[23:16] = 8'hFF;
   endfunction

   assign sw_data = {3{i_wdata}};
   assign sw_wr = i_wr ? lane_wr(i_addr, mifm_pkg::OFS_PEND_G0L) : 24'h0;

   // set by source, cleared on ack
   // byte writes replace the lane, so a written one sets the flag and a written zero clears it
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         pend_q <= {3{mifm_pkg::PEND_RST}};
      end else begin
         pend_q <= (((pend_q & ~sw_wr) | (sw_data & sw_wr)) & ~ack_clr | src_ev) & IMPL;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         mask_q <= {3{mifm_pkg::MASK_RST}};
      end else if (i_wr) begin
         mask_q <= (mask_q & ~lane_wr(i_addr, mifm_pkg::OFS_MASK_G0L)) |
                   (sw_data & lane_wr(i_addr, mifm_pkg::OFS_MASK_G0L));
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         lv0_q <= {3{mifm_pkg::LEVEL_RST}};
         lv1_q <= {3{mifm_pkg::LEVEL_RST}};
      end else if (i_wr) begin
         lv0_q <= (lv0_q & ~lane_wr(i_addr, mifm_pkg::OFS_LV0_G0L)) |
                  (sw_data & lane_wr(i_addr, mifm_pkg::OFS_LV0_G0L));
         lv1_q <= (lv1_q & ~lane_wr(i_addr, mifm_pkg::OFS_LV1_G0L)) |
                  (sw_data & lane_wr(i_addr, mifm_pkg::OFS_LV1_G0L));
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         rise_q <= mifm_pkg::EDGE_RST;
         fall_q <= mifm_pkg::EDGE_RST;
      end else if (i_wr && i_addr == mifm_pkg::OFS_RISE_EN) begin
         rise_q <= i_wdata;
      end else if (i_wr && i_addr == mifm_pkg::OFS_FALL_EN) begin
         fall_q <= i_wdata;
      end
   end

   // lowest index wins among equal levels
   // bit 3 mask and level shared by its sources
   // bit 4 mask and level shared by its sources
   always_comb begin
      cand_ok = 1'b0;
      win_id = 5'h0;
      win_lv = 2'h3;
      for (int i = N - 1; i >= 0; i--) begin
         if (pend_q[i] && !mask_q[i] && (!cand_ok || {lv1_q[i], lv0_q[i]} <= win_lv)) begin
            cand_ok = 1'b1;
            win_id = 5'(i);
            win_lv = {lv1_q[i], lv0_q[i]};
         end
      end
   end

   assign o_req = cand_ok && i_global_accept_enable &&
                  (win_lv < {i_in_service_level_bit1, i_in_service_level_bit0});
   assign o_req_id = win_id;

   always_comb begin
      ack_clr = '0;
      if (i_ack && o_req) ack_clr[win_id] = 1'b1;
   end

   // block events: sticky status, write one to clear, set wins
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         stat_q <= mifm_pkg::EV_RST;
      end else begin
         stat_q[mifm_pkg::EV_TRAP] <= trap_ev ||
            (stat_q[mifm_pkg::EV_TRAP] &&
             !(i_wr && i_addr == mifm_pkg::OFS_IRQ_STAT && i_wdata[mifm_pkg::EV_TRAP]));
         stat_q[mifm_pkg::EV_ACK] <= (i_ack && o_req) ||
            (stat_q[mifm_pkg::EV_ACK] &&
             !(i_wr && i_addr == mifm_pkg::OFS_IRQ_STAT && i_wdata[mifm_pkg::EV_ACK]));
         stat_q[mifm_pkg::EV_PEND] <= (|src_ev) ||
            (stat_q[mifm_pkg::EV_PEND] &&
             !(i_wr && i_addr == mifm_pkg::OFS_IRQ_STAT && i_wdata[mifm_pkg::EV_PEND]));
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         smask_q <= 3'h7;
      end else if (i_wr && i_addr == mifm_pkg::OFS_IRQ_MASK) begin
         smask_q <= i_wdata[2:0];
      end
   end

   assign o_irq = |(stat_q & ~smask_q);

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         case (i_addr)
            mifm_pkg::OFS_PEND_G0L: o_rdata <= pend_q[7:0];
            mifm_pkg::OFS_PEND_G0H: o_rdata <= pend_q[15:8];
            mifm_pkg::OFS_PEND_G1L: o_rdata <= pend_q[23:16];
            mifm_pkg::OFS_MASK_G0L: o_rdata <= mask_q[7:0];
            mifm_pkg::OFS_MASK_G0H: o_rdata <= mask_q[15:8];
            mifm_pkg::OFS_MASK_G1L: o_rdata <= mask_q[23:16];
            mifm_pkg::OFS_LV0_G0L: o_rdata <= lv0_q[7:0];
            mifm_pkg::OFS_LV0_G0H: o_rdata <= lv0_q[15:8];
            mifm_pkg::OFS_LV0_G1L: o_rdata <= lv0_q[23:16];
            mifm_pkg::OFS_LV1_G0L: o_rdata <= lv1_q[7:0];
            mifm_pkg::OFS_LV1_G0H: o_rdata <= lv1_q[15:8];
            mifm_pkg::OFS_LV1_G1L: o_rdata <= lv1_q[23:16];
            mifm_pkg::OFS_RISE_EN: o_rdata <= rise_q;
            mifm_pkg::OFS_FALL_EN: o_rdata <= fall_q;
            mifm_pkg::OFS_IRQ_STAT: o_rdata <= {5'h00, stat_q};
            default: o_rdata <= {5'h00, smask_q};
         endcase
      end else begin
         o_rdata <= 8'h00;
      end
   end

   chk_pend_reset: assert property (@(posedge i_clk_sys)
      i_rst |=> (pend_q == 24'h0) && (mask_q == 24'hFFFFFF))
      else $error("flags not at reset values");
   chk_mask_blocks: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_req |-> !mask_q[o_req_id] && pend_q[o_req_id])
      else $error("request from masked or idle source");
   chk_tx_shared: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_sync_serial_a_end_irq || i_simple_twowire_end_irq) |=> pend_q[3])
      else $error("shared tx flag not set");
   chk_accept_gate: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_req |-> i_global_accept_enable &&
               ({lv1_q[o_req_id], lv0_q[o_req_id]} <
                {i_in_service_level_bit1, i_in_service_level_bit0}))
      else $error("request without acceptance");
   chk_ack_clears: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_ack && o_req && !src_ev[o_req_id]) |=> !pend_q[$past(o_req_id)])
      else $error("acknowledged flag stayed set");
   chk_order_tie: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (o_req && o_req_id != 5'h0 && pend_q[0] && !mask_q[0]) |->
      ({lv1_q[0], lv0_q[0]} > {lv1_q[o_req_id], lv0_q[o_req_id]}))
      else $error("default order not respected");
   cov_req: cover property (@(posedge i_clk_sys) o_req && i_ack);
   cov_trap: cover property (@(posedge i_clk_sys) o_trap_reset);
   cov_shared_rx: cover property (@(posedge i_clk_sys) i_sync_serial_b_end_irq ##1 o_req);
endmodule

// [shared/mifm_pkg.sv]
/*
 * mifm_pkg: constants for the maskable interrupt flag mapper.
 * assumes: a byte-wide register port and 40 MHz system clock.
 */
package mifm_pkg;
   localparam int NUM_SRC = 19;
   localparam int ID_W = 5;
   // register offsets on the plain register port
   localparam logic [3:0] OFS_PEND_G0L = 4'h0;
   localparam logic [3:0] OFS_PEND_G0H = 4'h1;
   localparam logic [3:0] OFS_PEND_G1L = 4'h2;
   localparam logic [3:0] OFS_MASK_G0L = 4'h4;
   localparam logic [3:0] OFS_MASK_G0H = 4'h5;
   localparam logic [3:0] OFS_MASK_G1L = 4'h6;
   localparam logic [3:0] OFS_LV0_G0L = 4'h8;
   localparam logic [3:0] OFS_LV0_G0H = 4'h9;
   localparam logic [3:0] OFS_LV0_G1L = 4'hA;
   localparam logic [3:0] OFS_LV1_G0L = 4'hC;
   localparam logic [3:0] OFS_LV1_G0H = 4'hD;
   localparam logic [3:0] OFS_LV1_G1L = 4'hE;
   localparam logic [3:0] OFS_RISE_EN = 4'h3;
   localparam logic [3:0] OFS_FALL_EN = 4'h7;
   localparam logic [3:0] OFS_IRQ_STAT = 4'hB;
   localparam logic [3:0] OFS_IRQ_MASK = 4'hF;
   // reset values
   localparam logic [7:0] PEND_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'hFF;
   localparam logic [7:0] LEVEL_RST = 8'hFF;
   localparam logic [7:0] EDGE_RST = 8'h00;
   localparam logic [7:0] ILLEGAL_OPCODE = 8'hFF;
   // positions of the shared serial flags in group 0 low
   localparam int BIT_TX_SHARED = 3;
   localparam int BIT_RX_SHARED = 4;
   // status bits of the block's own events
   localparam int EV_TRAP = 0;
   localparam int EV_ACK = 1;
   localparam int EV_PEND = 2;
   localparam logic [2:0] EV_RST = 3'h0;
   // internal trap reset pulse width
   localparam int TRAP_RST_NS = 100;
   localparam int CLK_NS = 25;
   localparam int TRAP_RST_CYC = (TRAP_RST_NS + CLK_NS - 1) / CLK_NS;
endpackage

// [hdl/mifm_edge_detect.sv]
/*
 * mifm_edge_detect: synchronises external pin levels and flags edges.
 * assumes: pins are asynchronous; enables come from same-clock registers.
 */
`timescale 1ns/1ps
module mifm_edge_detect #(
   parameter int N = 4
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [N-1:0] i_pin,
   input wire logic [N-1:0] i_rise_en,
   input wire logic [N-1:0] i_fall_en,
   output logic [N-1:0] o_edge
);
   logic [N-1:0] meta_q;
   logic [N-1:0] sync_q;
   logic [N-1:0] last_q;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= i_pin;
         sync_q <= meta_q;
      end
   end

   // last level follows the synchronised level only
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         last_q <= '0;
      end else begin
         last_q <= sync_q;
      end
   end

   assign o_edge = (i_rise_en & sync_q & ~last_q) | (i_fall_en & ~sync_q & last_q);
endmodule

// [hdl/mifm_trap_reset.sv]
/*
 * mifm_trap_reset: internal reset on the illegal opcode.
 * assumes: opcode strobe is one cycle per executed instruction.
 */
`timescale 1ns/1ps
module mifm_trap_reset (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_exec_valid,
   input wire logic [7:0] i_exec_opcode,
   input wire logic i_debug_active,
   output logic o_trap_reset,
   output logic o_trap_event
);
   logic [3:0] cnt_q;

   assign o_trap_event = i_exec_valid && !i_debug_active &&
                         (i_exec_opcode == mifm_pkg::ILLEGAL_OPCODE);

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         cnt_q <= 4'h0;
      end else if (o_trap_event) begin
         cnt_q <= 4'(mifm_pkg::TRAP_RST_CYC);
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
      end
   end

   assign o_trap_reset = (cnt_q != 4'h0);

   chk_trap_no_debug: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_exec_valid && i_debug_active) |=> (cnt_q == $past(cnt_q) - 4'h1) || (cnt_q == 4'h0))
      else $error("trap reset raised during debug");
   chk_trap_raise: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_exec_valid && !i_debug_active && i_exec_opcode == 8'hFF) |=> o_trap_reset [*4])
      else $error("illegal opcode gave no reset pulse");
endmodule

// [verification/mifm_cpu_model.sv]
/*
 * mifm_cpu_model: behavioural cpu core on the far side of the mapper.
 * assumes: one system clock; the bench sets global enable, in-service
 * level and whether and how slowly requests are acknowledged.
 */
`timescale 1ns/1ps
module mifm_cpu_model (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_req,
   input wire logic i_auto,
   input wire logic [3:0] i_delay,
   input wire logic i_enable,
   input wire logic [1:0] i_level,
   output logic o_ack,
   output logic o_global_accept_enable,
   output logic o_in_service_level_bit0,
   output logic o_in_service_level_bit1
);
   logic [3:0] cnt_q;
   assign o_global_accept_enable = i_enable;
   assign o_in_service_level_bit0 = i_level[0];
   assign o_in_service_level_bit1 = i_level[1];
   // one-cycle acknowledge; a slow core waits i_delay cycles first
   always_ff @(posedge i_clk_sys) begin
      if (i_rst || o_ack || !i_req || !i_auto) begin
         cnt_q <= 4'h0;
         o_ack <= 1'b0;
      end else if (cnt_q == i_delay) begin
         o_ack <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
endmodule

// [verification/tb_maskable_interrupt_flag_mapper.sv]
/*
 * tb_maskable_interrupt_flag_mapper: register-port sequences with expected
 * values for the interrupt flag mapper, large package and the small package beside it.
 * assumes: design package constants and the cpu model beside it.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_maskable_interrupt_flag_mapper;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, xv = 1'b0, dbg = 1'b0;
   logic [3:0] addr = 4'h0, pin = 4'h0, dly = 4'h0;
   logic [7:0] wd = 8'h00, xop = 8'h00, rdata, rdata_s;
   logic [18:0] src = '0;
   logic [2:0] ser = 3'h0;
   logic auto = 1'b0, ena = 1'b0, ack, ie, in_service_level_bit0, in_service_level_bit1, req, trap, irq;
   logic [1:0] lvl = 2'h3;
   logic [4:0] rid;
   logic [4:0] ids[$];
   int miscompares = 0, n_checks = 0, nt;
   always #12.5 clk = ~clk;
   mifm_top #(.LARGE_PKG(1'b1)) uut (.i_clk_sys(clk), .i_rst(rst), .i_addr(addr),
      .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_watchdog_interval_irq(src[0]), .i_external_pin_irq(pin),
      .i_uart_tx_end_irq(src[3]), .i_sync_serial_a_end_irq(ser[0]),
      .i_simple_twowire_end_irq(ser[1]), .i_uart_rx_end_irq(src[4]),
      .i_sync_serial_b_end_irq(ser[2]), .i_uart_rx_error_irq(src[5]),
      .i_timer_ch1_upper_irq(src[6]), .i_timer_ch0_irq(src[7]),
      .i_timer_ch1_irq(src[8]), .i_conversion_done_irq(src[9]),
      .i_key_return_irq(src[10]), .i_timer_ch3_upper_irq(src[13]),
      .i_full_twowire_end_irq(src[14]), .i_timer_ch2_irq(src[15]),
      .i_timer_ch3_irq(src[16]), .i_interval_timer_irq(src[17]),
      .i_comparator_edge_irq(src[18]), .i_global_accept_enable(ie),
      .i_in_service_level_bit0(in_service_level_bit0), .i_in_service_level_bit1(in_service_level_bit1), .i_ack(ack),
      .i_exec_valid(xv), .i_exec_opcode(xop), .i_debug_active(dbg),
      .o_req(req), .o_req_id(rid), .o_trap_reset(trap), .o_irq(irq));
   // small package beside the large one, fed by the same port and sources
   mifm_top #(.LARGE_PKG(1'b0)) uut_small (.i_clk_sys(clk), .i_rst(rst), .i_addr(addr),
      .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata_s),
      .i_watchdog_interval_irq(src[0]), .i_external_pin_irq(pin),
      .i_uart_tx_end_irq(src[3]), .i_sync_serial_a_end_irq(ser[0]),
      .i_simple_twowire_end_irq(ser[1]), .i_uart_rx_end_irq(src[4]),
      .i_sync_serial_b_end_irq(ser[2]), .i_uart_rx_error_irq(src[5]),
      .i_timer_ch1_upper_irq(src[6]), .i_timer_ch0_irq(src[7]),
      .i_timer_ch1_irq(src[8]), .i_conversion_done_irq(src[9]),
      .i_key_return_irq(src[10]), .i_timer_ch3_upper_irq(src[13]),
      .i_full_twowire_end_irq(src[14]), .i_timer_ch2_irq(src[15]),
      .i_timer_ch3_irq(src[16]), .i_interval_timer_irq(src[17]),
      .i_comparator_edge_irq(src[18]), .i_global_accept_enable(ie),
      .i_in_service_level_bit0(in_service_level_bit0), .i_in_service_level_bit1(in_service_level_bit1), .i_ack(1'b0),
      .i_exec_valid(xv), .i_exec_opcode(xop), .i_debug_active(dbg),
      .o_req(), .o_req_id(), .o_trap_reset(), .o_irq());
   mifm_cpu_model cpu (.i_clk_sys(clk), .i_rst(rst), .i_req(req), .i_auto(auto),
      .i_delay(dly), .i_enable(ena), .i_level(lvl), .o_ack(ack),
      .o_global_accept_enable(ie), .o_in_service_level_bit0(in_service_level_bit0),
      .o_in_service_level_bit1(in_service_level_bit1));
   // the winner is sampled on the acknowledge edge, before its flag drops
   always @(posedge clk) if (ack === 1'b1) ids.push_back(rid);
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a; wd <= d; wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a; rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 `CHK(rdata, e)
   endtask
   task automatic pulse(input logic [18:0] m, input logic [2:0] s);
      @(posedge clk);
      src <= m; ser <= s;
      @(posedge clk);
      src <= '0; ser <= 3'h0;
      #1;
   endtask
   // byte clears of all three lanes; a source firing on the write edge still sets its flag, as the source wins
   task automatic clr_pend();
      for (int i = 0; i < 3; i++) wr_reg(4'(i), 8'h00);
   endtask
   task automatic exec(input logic [7:0] op, input logic d);
      @(posedge clk);
      xv <= 1'b1; xop <= op; dbg <= d;
      nt = 0;
      repeat (10) begin
         @(posedge clk);
         xv <= 1'b0;
         #1 if (trap === 1'b1) nt++;
      end
   endtask
   task automatic summarize();
      if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #(25 * 4000);
      miscompares++;
      summarize();
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         rd_chk(4'(i), mifm_pkg::PEND_RST);
         rd_chk(4'(i + 4), mifm_pkg::MASK_RST);
         rd_chk(4'(i + 8), mifm_pkg::LEVEL_RST);
         rd_chk(4'(i + 12), mifm_pkg::LEVEL_RST);
      end
      #1 `CHK({req, irq}, 2'b00)
      // every internal source except the three serial ones on ser, at once, lands on its own flag
      pulse(19'h7E7F9, 3'h0);
      rd_chk(mifm_pkg::OFS_PEND_G0L, 8'hF9);
      rd_chk(mifm_pkg::OFS_PEND_G0H, 8'hE7);
      `CHK(rdata_s, 8'h07)
      rd_chk(mifm_pkg::OFS_PEND_G1L, 8'h07);
      `CHK(rdata_s, 8'h00)
      clr_pend();
      for (int k = 0; k < 3; k++) begin
         pulse('0, 3'(1 << k));
         rd_chk(mifm_pkg::OFS_PEND_G0L, 8'(k < 2 ? 8'h08 : 8'h10));
         `CHK(rdata_s, 8'(k < 2 ? 8'h08 : 8'h00))
         clr_pend();
      end
      pulse(19'h00018, 3'h0);
      rd_chk(mifm_pkg::OFS_PEND_G0L, 8'h18);
      clr_pend();
      wr_reg(mifm_pkg::OFS_RISE_EN, 8'h09);
      wr_reg(mifm_pkg::OFS_FALL_EN, 8'h02);
      @(posedge clk) pin <= 4'hB;
      repeat (6) @(posedge clk);
      rd_chk(mifm_pkg::OFS_PEND_G0L, 8'h02);
      rd_chk(mifm_pkg::OFS_PEND_G0H, 8'h10);
      `CHK(rdata_s, 8'h00)
      clr_pend();
      @(posedge clk) pin <= 4'h0;
      repeat (6) @(posedge clk);
      rd_chk(mifm_pkg::OFS_PEND_G0L, 8'h04);
      clr_pend();
      for (int i = 4; i < 16; i++) if (i % 4 != 3) wr_reg(4'(i), 8'h00);
      @(posedge clk) ena <= 1'b1;
      pulse(19'h00080, 3'h1);
      `CHK({req, rid}, 6'h23)
      @(posedge clk) auto <= 1'b1; dly <= 4'h2;
      repeat (12) @(posedge clk);
      `CHK(ids.size(), 2)
      `CHK({ids[0], ids[1]}, 10'h067)
      rd_chk(mifm_pkg::OFS_PEND_G0L, 8'h00);
      @(posedge clk) auto <= 1'b0;
      wr_reg(mifm_pkg::OFS_LV0_G0L, 8'h08);
      pulse(19'h00088, 3'h0);
      `CHK({req, rid}, 6'h27)
      @(posedge clk) lvl <= 2'h0;
      #1 `CHK(req, 1'b0)
      @(posedge clk) lvl <= 2'h3; ena <= 1'b0;
      #1 `CHK(req, 1'b0)
      @(posedge clk) ena <= 1'b1;
      wr_reg(mifm_pkg::OFS_MASK_G0L, 8'h80);
      #1 `CHK({req, rid}, 6'h23)
      wr_reg(mifm_pkg::OFS_MASK_G0L, 8'h88);
      #1 `CHK(req, 1'b0)
      clr_pend();
      exec(8'h00, 1'b0);
      `CHK(nt, 0)
      exec(mifm_pkg::ILLEGAL_OPCODE, 1'b1);
      `CHK(nt, 0)
      wr_reg(mifm_pkg::OFS_IRQ_STAT, 8'hFF);
      wr_reg(mifm_pkg::OFS_IRQ_MASK, 8'h06);
      #1 `CHK(irq, 1'b0)
      exec(mifm_pkg::ILLEGAL_OPCODE, 1'b0);
      `CHK(nt, mifm_pkg::TRAP_RST_CYC)
      rd_chk(mifm_pkg::OFS_IRQ_STAT, 8'h01);
      `CHK(irq, 1'b1)
      wr_reg(mifm_pkg::OFS_IRQ_MASK, 8'h07);
      #1 `CHK(irq, 1'b0)
      wr_reg(mifm_pkg::OFS_IRQ_MASK, 8'h06);
      wr_reg(mifm_pkg::OFS_IRQ_STAT, 8'h01);
      #1 `CHK(irq, 1'b0)
      summarize();
   end
endmodule
